// >>> inc/uad_pkg.sv
package uad_pkg;

  // ****************************************
  // Line selection
  // ****************************************
  localparam int unsigned  SEL_W        = 5;
  localparam logic [4:0]   SEL_INTERNAL = 5'h10;  // Internal D+ pull-up code
  localparam int unsigned  MAX_GPIO     = 16;

  // ****************************************
  // Register byte offsets
  // ****************************************
  localparam logic [7:0] OFS_CTRL      = 8'h00;
  localparam logic [7:0] OFS_PULLUP    = 8'h04;
  localparam logic [7:0] OFS_BUS_PWR   = 8'h08;
  localparam logic [7:0] OFS_DETACH    = 8'h0C;
  localparam logic [7:0] OFS_WAKE      = 8'h10;
  localparam logic [7:0] OFS_STATUS    = 8'h14;
  localparam logic [7:0] OFS_IRQ_STAT  = 8'h18;
  localparam logic [7:0] OFS_IRQ_MASK  = 8'h1C;
  localparam logic [7:0] OFS_POWER     = 8'h20;

  // ****************************************
  // Field positions and reset values
  // ****************************************
  localparam int unsigned CTRL_READY    = 0;
  localparam int unsigned CTRL_SELF_PWR = 1;
  localparam int unsigned CTRL_EP_AUDIO = 2;
  localparam int unsigned CTRL_WAKE_REQ = 3;
  localparam int unsigned CTRL_W        = 4;
  localparam logic [3:0]  CTRL_RST      = 4'h0;
  // Out of reset no line is claimed, so no pin is driven or obeyed until set
  localparam logic [4:0]  SEL_RST       = 5'h1F;

  localparam int unsigned STAT_VBUS     = 0;
  localparam int unsigned STAT_DETACHED = 1;
  localparam int unsigned STAT_SUSP     = 2;
  localparam int unsigned STAT_PULLUP   = 3;
  localparam int unsigned STAT_RADIO    = 4;
  localparam int unsigned STAT_WAKE     = 5;
  localparam int unsigned STAT_STATE    = 8;

  localparam int unsigned IRQ_VBUS_ON   = 0;
  localparam int unsigned IRQ_VBUS_OFF  = 1;
  localparam int unsigned IRQ_DETACH    = 2;
  localparam int unsigned IRQ_REATTACH  = 3;
  localparam int unsigned IRQ_SUSPEND   = 4;
  localparam int unsigned IRQ_RESUME    = 5;
  localparam int unsigned IRQ_W         = 6;

  // ****************************************
  // Power and link figures
  // ****************************************
  localparam int unsigned FS_BIT_RATE_BPS = 12_000_000;
  localparam int unsigned MAX_POWER_MA    = 100;
  localparam int unsigned POWER_UNIT_MA   = 2;
  localparam logic [7:0]  MAX_POWER_CODE  = 8'(MAX_POWER_MA / POWER_UNIT_MA);

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [2:0] {
    ST_UNPOWERED  = 3'b000,
    ST_WAIT_READY = 3'b001,
    ST_ATTACHED   = 3'b011,
    ST_SUSPENDED  = 3'b010,
    ST_DETACHED   = 3'b110
  } uad_state_t;

  typedef struct packed {
    logic dp;
    logic dm;
    logic oe;
  } uad_usb_tx_t;

  typedef struct packed {
    logic dp_o;
    logic dp_oe;
    logic dm_o;
    logic dm_oe;
  } uad_usb_pad_t;

endpackage : uad_pkg

// >>> hw/uad_sync.sv
`timescale 1ns/1ns
// Two-flop synchroniser for a group of pin levels
module uad_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         hclk,
  input  wire logic         hresetn,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  logic [W-1:0] meta_ff;
  logic [W-1:0] dout_ff;

  // First stage feeds only the second stage
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta_ff <= '0;
      dout_ff <= '0;
    end else begin
      meta_ff <= din;
      dout_ff <= meta_ff;
    end
  end

  assign dout = dout_ff;

endmodule : uad_sync

// >>> hw/uad_line_mux.sv
`timescale 1ns/1ns
// Picks one general I/O line by its number
module uad_line_mux
  import uad_pkg::*;
#(
  parameter int unsigned N = 16
) (
  input  wire logic [N-1:0]     lines,
  input  wire logic [SEL_W-1:0] sel,
  output logic                  hit,
  output logic                  level
);

  // Code 16 and above must stay free for internal and unmapped choices
  if (N < 1 || N > MAX_GPIO) begin : g_bad_n
    $error("uad_line_mux: N must be 1 to 16");
  end

  // Numbers beyond the fitted lines read low and report no hit
  always_comb begin
    hit   = 1'b0;
    level = 1'b0;
    for (int i = 0; i < N; i++) begin
      if (sel == SEL_W'(i)) begin
        hit   = 1'b1;
        level = lines[i];
      end
    end
  end

endmodule : uad_line_mux

// >>> hw/uad_ctrl.sv
// Decided for this implementation: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/1ns
// What this block does
// RQ1 - Full-speed 12 Mbit/s port drives D+/D- pads directly, no transceiver.
// RQ2 - Peripheral only: pads only carry core answers, never host signalling.
// RQ3 - Software chooses standard endpoint set or audio endpoint set.
// RQ4 - D+ pull-up enabled only once software marks ready to enumerate.
// RQ5 - Pull-up selection picks internal or external line; internal by default.
// RQ6 - Pull-up selection value 16 means internal pull-up, the reset value.
// RQ7 - Self-powered: bus power sensed on the line held in its selection.
// RQ8 - Without bus power, D+ is released and no pull-up is driven.
// RQ9 - Self-powered software sets pull-up selection to the external line.
// RQ10 - Bus-powered device requests 100 mA at enumeration.
// RQ11 - Host may suspend us; bus-powered suspend stops the radio.
// RQ12 - Detach input and wake output each mapped to any chosen line.
// RQ13 - Detach high floats both data lines and removes the D+ pull-up.
// RQ14 - Detach low reconnects and waits for a fresh enumeration.
// RQ15 - Wake output active high, asserted only while detach is active.
// RQ16 - No in-band wake while detached; the wake line replaces it.
// RQ17 - Detach input synchronised to the clock before use.
module uad_ctrl
  import uad_pkg::*;
#(
  parameter int unsigned NUM_GPIO = 16
) (
  input  wire logic                hclk,
  input  wire logic                hresetn,
  input  wire logic                hsel,
  input  wire logic [31:0]         haddr,
  input  wire logic [1:0]          htrans,
  input  wire logic                hwrite,
  input  wire logic [2:0]          hsize,
  input  wire logic [31:0]         hwdata,
  input  wire logic                hready,
  output logic      [31:0]         hrdata,
  output logic                     hreadyout,
  output logic                     hresp,
  input  wire uad_usb_tx_t         core_tx,
  input  wire logic                core_suspend,
  input  wire logic                core_resume_req,
  output logic                     core_resume,
  output logic                     core_reattach,
  output logic                     ep_set_audio,
  output logic      [7:0]          max_power,
  output uad_usb_pad_t             usb_pad,
  output logic                     pullup_int_en,
  input  wire logic [NUM_GPIO-1:0] gpio_i,
  output logic      [NUM_GPIO-1:0] gpio_o,
  output logic      [NUM_GPIO-1:0] gpio_oe,
  output logic                     radio_en,
  output logic                     irq
);

  // ****************************************
  // Elaboration checks
  // ****************************************
  // Code 16 is reserved for the internal pull-up, so at most 16 lines
  if (NUM_GPIO < 1 || NUM_GPIO > MAX_GPIO) begin : g_bad_gpio
    $error("uad_ctrl: NUM_GPIO must be 1 to 16");
  end

  // ****************************************
  // Declarations
  // ****************************************
  logic [CTRL_W-1:0] ctrl_ff;
  logic [SEL_W-1:0]  pullup_sel_ff;
  logic [SEL_W-1:0]  bus_pwr_sel_ff;
  logic [SEL_W-1:0]  detach_sel_ff;
  logic [SEL_W-1:0]  wake_sel_ff;
  logic [IRQ_W-1:0]  irq_stat_ff;
  logic [IRQ_W-1:0]  irq_mask_ff;
  logic [IRQ_W-1:0]  irq_evt;
  logic [IRQ_W-1:0]  irq_clr;
  uad_state_t        state_ff;
  uad_state_t        nxt_state;
  logic              wr_pend_ff;
  logic [7:0]        addr_ff;
  logic              bus_take;
  logic              wr_ok;
  logic [NUM_GPIO-1:0] gpio_s;
  logic              vbus_hit;
  logic              vbus_line;
  logic              det_hit;
  logic              det_line;
  logic              wake_hit;
  logic              vbus_ok;
  logic              vbus_prev_ff;
  logic              det_prev_ff;
  logic              connected;
  logic              pullup_on;
  logic              use_int_pu;
  logic              wake_ff;
  logic              reattach_ff;
  logic              pu_int_ff;
  logic [NUM_GPIO-1:0] nxt_gpio_o;
  logic [NUM_GPIO-1:0] nxt_gpio_oe;
  logic [NUM_GPIO-1:0] gpio_o_ff;
  logic [NUM_GPIO-1:0] gpio_oe_ff;
  logic [31:0]       status_word;

  // ****************************************
  // Pin synchronisation and line selection
  // ****************************************
  // Every line, detach included, is double-flopped before any use
  uad_sync #(
    .W       (NUM_GPIO)
  ) u_sync (
    .hclk    (hclk),
    .hresetn (hresetn),
    .din     (gpio_i),
    .dout    (gpio_s)  // RQ17
  );

  // Bus power sense line
  uad_line_mux #(
    .N     (NUM_GPIO)
  ) u_vbus_mux (
    .lines (gpio_s),
    .sel   (bus_pwr_sel_ff),  // RQ7
    .hit   (vbus_hit),
    .level (vbus_line)
  );

  // Detach request line
  uad_line_mux #(
    .N     (NUM_GPIO)
  ) u_det_mux (
    .lines (gpio_s),
    .sel   (detach_sel_ff),  // RQ12
    .hit   (det_hit),
    .level (det_line)
  );

  // Wake line only needs the hit; its level is ours to drive
  uad_line_mux #(
    .N     (NUM_GPIO)
  ) u_wake_mux (
    .lines (gpio_s),
    .sel   (wake_sel_ff),  // RQ12
    .hit   (wake_hit),
    .level ()
  );

  // Bus-powered parts run from the cable, so power is present by definition
  assign vbus_ok = ctrl_ff[CTRL_SELF_PWR] ? (vbus_hit & vbus_line) : 1'b1;  // RQ7

  // ****************************************
  // AHB-Lite slave
  // ****************************************
  // Zero wait states; only whole-word writes change state
  assign bus_take  = hsel & htrans[1] & hready;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // Address phase capture
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_ff <= 1'b0;
      addr_ff    <= 8'h00;
    end else if (hready) begin
      wr_pend_ff <= bus_take & hwrite & (hsize == 3'b010);
      addr_ff    <= bus_take ? haddr[7:0] : 8'h00;
    end
  end

  assign wr_ok = wr_pend_ff;

  // Control and selection registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_ff        <= CTRL_RST;
      pullup_sel_ff  <= SEL_INTERNAL;  // RQ6
      bus_pwr_sel_ff <= SEL_RST;
      detach_sel_ff  <= SEL_RST;
      wake_sel_ff    <= SEL_RST;
      irq_mask_ff    <= '0;
    end else if (wr_ok) begin
      case (addr_ff)
        OFS_CTRL:     ctrl_ff        <= hwdata[CTRL_W-1:0];  // RQ3
        OFS_PULLUP:   pullup_sel_ff  <= hwdata[SEL_W-1:0];   // RQ5
        OFS_BUS_PWR:  bus_pwr_sel_ff <= hwdata[SEL_W-1:0];
        OFS_DETACH:   detach_sel_ff  <= hwdata[SEL_W-1:0];
        OFS_WAKE:     wake_sel_ff    <= hwdata[SEL_W-1:0];
        OFS_IRQ_MASK: irq_mask_ff    <= hwdata[IRQ_W-1:0];
        default: ;
      endcase
    end
  end

  // Status word assembled from live state
  always_comb begin
    status_word = 32'h0000_0000;
    status_word[STAT_VBUS]     = vbus_ok;
    status_word[STAT_DETACHED] = (state_ff == ST_DETACHED);
    status_word[STAT_SUSP]     = (state_ff == ST_SUSPENDED);
    status_word[STAT_PULLUP]   = pullup_on;
    status_word[STAT_RADIO]    = radio_en;
    status_word[STAT_WAKE]     = wake_ff;
    status_word[STAT_STATE +: 3] = state_ff;
  end

  // Read mux from the captured address; unmapped reads as zero
  always_comb begin
    hrdata = 32'h0000_0000;
    case (addr_ff)
      OFS_CTRL:     hrdata[CTRL_W-1:0] = ctrl_ff;
      OFS_PULLUP:   hrdata[SEL_W-1:0]  = pullup_sel_ff;
      OFS_BUS_PWR:  hrdata[SEL_W-1:0]  = bus_pwr_sel_ff;
      OFS_DETACH:   hrdata[SEL_W-1:0]  = detach_sel_ff;
      OFS_WAKE:     hrdata[SEL_W-1:0]  = wake_sel_ff;
      OFS_STATUS:   hrdata             = status_word;
      OFS_IRQ_STAT: hrdata[IRQ_W-1:0]  = irq_stat_ff;
      OFS_IRQ_MASK: hrdata[IRQ_W-1:0]  = irq_mask_ff;
      OFS_POWER:    hrdata[7:0]        = max_power;  // RQ10
      default:      hrdata             = 32'h0000_0000;
    endcase
  end

  // ****************************************
  // Attach state machine
  // ****************************************
  // Power loss dominates, then detach, then the normal path
  always_comb begin
    nxt_state = state_ff;
    if (!vbus_ok) begin
      nxt_state = ST_UNPOWERED;  // RQ8
    end else if (det_hit & det_line) begin
      nxt_state = ST_DETACHED;  // RQ13
    end else begin
      case (state_ff)
        ST_UNPOWERED:  nxt_state = ST_WAIT_READY;
        ST_WAIT_READY: begin
          if (ctrl_ff[CTRL_READY]) begin
            nxt_state = ST_ATTACHED;  // RQ4
          end
        end
        ST_ATTACHED: begin
          if (!ctrl_ff[CTRL_READY]) begin
            nxt_state = ST_WAIT_READY;
          end else if (core_suspend) begin
            nxt_state = ST_SUSPENDED;  // RQ11
          end
        end
        ST_SUSPENDED: begin
          if (!ctrl_ff[CTRL_READY]) begin
            nxt_state = ST_WAIT_READY;
          end else if (!core_suspend) begin
            nxt_state = ST_ATTACHED;
          end
        end
        ST_DETACHED:   nxt_state = ST_WAIT_READY;  // RQ14
        default:       nxt_state = ST_UNPOWERED;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_ff <= ST_UNPOWERED;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Reattach pulse lets the core drop its address and await enumeration
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      reattach_ff <= 1'b0;
    end else begin
      reattach_ff <= (state_ff == ST_DETACHED) & (nxt_state != ST_DETACHED);  // RQ14
    end
  end

  // ****************************************
  // Pads, pull-ups and wake line
  // ****************************************
  assign connected  = (state_ff == ST_ATTACHED) | (state_ff == ST_SUSPENDED);
  assign pullup_on  = connected;  // RQ4 RQ8 RQ13
  assign use_int_pu = (pullup_sel_ff == SEL_INTERNAL);  // RQ6

  // Pads carry only core answers; floated whenever not connected
  assign usb_pad.dp_o  = core_tx.dp;  // RQ1
  assign usb_pad.dm_o  = core_tx.dm;
  assign usb_pad.dp_oe = connected & core_tx.oe;  // RQ2 RQ13
  assign usb_pad.dm_oe = connected & core_tx.oe;  // RQ13

  // Wake only while detached and software asks for it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wake_ff <= 1'b0;
    end else begin
      wake_ff <= (nxt_state == ST_DETACHED) & ctrl_ff[CTRL_WAKE_REQ];  // RQ15
    end
  end

  // External pull-up drives high only when powered and ready; else released
  always_comb begin
    nxt_gpio_o  = '0;
    nxt_gpio_oe = '0;
    for (int i = 0; i < NUM_GPIO; i++) begin
      if (!use_int_pu && pullup_sel_ff == SEL_W'(i) && pullup_on) begin
        nxt_gpio_o[i]  = 1'b1;  // RQ5 RQ9
        nxt_gpio_oe[i] = 1'b1;
      end
      if (wake_hit && wake_sel_ff == SEL_W'(i)) begin
        nxt_gpio_o[i]  = nxt_gpio_o[i] | wake_ff;  // RQ15
        nxt_gpio_oe[i] = 1'b1;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gpio_o_ff  <= '0;
      gpio_oe_ff <= '0;
      pu_int_ff  <= 1'b0;
    end else begin
      gpio_o_ff  <= nxt_gpio_o;
      gpio_oe_ff <= nxt_gpio_oe;
      pu_int_ff  <= use_int_pu & pullup_on;  // RQ4 RQ5
    end
  end

  assign gpio_o        = gpio_o_ff;
  assign gpio_oe       = gpio_oe_ff;
  assign pullup_int_en = pu_int_ff;
  assign core_reattach = reattach_ff;

  // ****************************************
  // Power mode outputs
  // ****************************************
  // In-band resume is passed on only from suspend, never when detached
  assign core_resume  = core_resume_req & (state_ff == ST_SUSPENDED);  // RQ16
  assign radio_en     = !((state_ff == ST_SUSPENDED) & !ctrl_ff[CTRL_SELF_PWR]);  // RQ11
  assign max_power    = ctrl_ff[CTRL_SELF_PWR] ? 8'h00 : MAX_POWER_CODE;  // RQ10
  assign ep_set_audio = ctrl_ff[CTRL_EP_AUDIO];  // RQ3

  // ****************************************
  // Interrupts
  // ****************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      // Bus-powered out of reset sees power at once; avoid a false power-on event
      vbus_prev_ff <= 1'b1;
      det_prev_ff  <= 1'b0;
    end else begin
      vbus_prev_ff <= vbus_ok;
      det_prev_ff  <= (state_ff == ST_DETACHED);
    end
  end

  // Events taken from edges of power and state
  always_comb begin
    irq_evt = '0;
    irq_evt[IRQ_VBUS_ON]  = vbus_ok & !vbus_prev_ff;
    irq_evt[IRQ_VBUS_OFF] = !vbus_ok & vbus_prev_ff;
    irq_evt[IRQ_DETACH]   = (state_ff == ST_DETACHED) & !det_prev_ff;
    irq_evt[IRQ_REATTACH] = reattach_ff;
    irq_evt[IRQ_SUSPEND]  = (nxt_state == ST_SUSPENDED) & (state_ff == ST_ATTACHED);
    irq_evt[IRQ_RESUME]   = (nxt_state == ST_ATTACHED) & (state_ff == ST_SUSPENDED);
  end

  assign irq_clr = (wr_ok && addr_ff == OFS_IRQ_STAT) ? hwdata[IRQ_W-1:0] : '0;

  // Write one to clear; a new event in the same cycle wins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_stat_ff <= '0;
    end else begin
      irq_stat_ff <= (irq_stat_ff & ~irq_clr) | irq_evt;
    end
  end

  assign irq = |(irq_stat_ff & irq_mask_ff);

endmodule : uad_ctrl

// >>> test/uad_ctrl_assertions.sv
`timescale 1ns/1ns
// Watches the pad, power and pulse outputs of the control block
module uad_ctrl_chk
  import uad_pkg::*;
(
  input wire logic         hclk,
  input wire logic         hresetn,
  input wire logic         hreadyout,
  input wire logic         hresp,
  input wire uad_usb_tx_t  core_tx,
  input wire logic         core_suspend,
  input wire logic         core_resume_req,
  input wire logic         core_resume,
  input wire logic         core_reattach,
  input wire logic [7:0]   max_power,
  input wire uad_usb_pad_t usb_pad,
  input wire logic         radio_en
);
  // ****************************************
  // Properties
  // ****************************************
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  ahb_okay_a: assert property (hreadyout && !hresp)
    else $error("bus slave stalled or errored");
  pads_follow_a: assert property (
    usb_pad.dp_o == core_tx.dp && usb_pad.dm_o == core_tx.dm)
    else $error("pad levels differ from core levels");
  pad_gated_a: assert property (usb_pad.dp_oe |-> core_tx.oe)
    else $error("pad driven without a core request");
  lines_together_a: assert property (usb_pad.dp_oe == usb_pad.dm_oe)
    else $error("data lines enabled apart");
  power_code_a: assert property (
    max_power == MAX_POWER_CODE || max_power == 8'h00)
    else $error("power request code out of range");
  radio_stop_a: assert property (!radio_en |-> max_power == MAX_POWER_CODE)
    else $error("radio stopped while self powered");
  radio_cause_a: assert property ($fell(radio_en) |-> $past(core_suspend))
    else $error("radio stopped without bus suspend");
  resume_gate_a: assert property (core_resume |-> core_resume_req && $past(core_suspend))
    else $error("in-band resume without request or suspend");
  reattach_pulse_a: assert property (core_reattach |=> !core_reattach)
    else $error("reattach pulse longer than one cycle");

  // Main scenarios reached
  cover property (core_reattach);
  cover property (!radio_en);
  cover property (core_resume);
endmodule : uad_ctrl_chk

bind uad_ctrl uad_ctrl_chk chk_u (.hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout),
  .hresp(hresp), .core_tx(core_tx), .core_suspend(core_suspend),
  .core_resume_req(core_resume_req), .core_resume(core_resume),
  .core_reattach(core_reattach), .max_power(max_power), .usb_pad(usb_pad),
  .radio_en(radio_en));

// >>> test/uad_host_model.sv
`timescale 1ns/1ns
// Host side: bus power, detach request, bus idle and the pins it sees
module uad_host_model #(
  parameter int unsigned DET = 3,
  parameter int unsigned VB  = 7,
  parameter int unsigned PU  = 9,
  parameter int unsigned WK  = 5
) (
  input  wire logic        hclk,
  input  wire logic        det_req,
  input  wire logic        vbus_on,
  input  wire logic        bus_idle,
  input  wire logic        pullup_int_en,
  input  wire logic [15:0] gpio_o,
  input  wire logic [15:0] gpio_oe,
  output logic      [15:0] gpio_i,
  output logic             core_suspend,
  output logic             host_att,
  output logic             wake_seen
);
  // Released lines sit at their weak pull-up, never at a stale level; released DET and VB follow det_req and vbus_on
  always_comb begin
    for (int n = 0; n < 16; n++) begin
      gpio_i[n] = gpio_oe[n] ? gpio_o[n] : 1'b1;
    end
    if (!gpio_oe[DET]) gpio_i[DET] = det_req;
    if (!gpio_oe[VB]) gpio_i[VB] = vbus_on;
  end
  // Host counts a device once any D+ pull-up shows
  assign host_att  = pullup_int_en | (gpio_oe[PU] & gpio_o[PU]);
  assign wake_seen = gpio_oe[WK] & gpio_o[WK];
  // Core notices bus idle one cycle after the host stops traffic
  initial core_suspend = 1'b0;
  always @(posedge hclk) core_suspend <= bus_idle;
endmodule : uad_host_model

// >>> test/tb_top.sv
`timescale 1ns/1ns
module tb_top
  import uad_pkg::*;
;
  logic         hclk, hresetn, hsel, hwrite, core_resume_req, rd_ph;
  logic         det_req, vbus_on, bus_idle, hreadyout, hresp, core_suspend;
  logic         core_resume, core_reattach, ep_set_audio, pullup_int_en;
  logic         radio_en, irq, host_att, wake_seen;
  logic [31:0]  haddr, hwdata, hrdata, rng, m, e;
  logic [1:0]   htrans;
  logic [2:0]   hsize;
  logic [7:0]   max_power;
  logic [15:0]  gpio_i, gpio_o, gpio_oe;
  uad_usb_tx_t  core_tx;
  uad_usb_pad_t usb_pad;
  logic [31:0]  expq[$];
  int           n_mismatch, samples_checked, i;

  uad_ctrl dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .core_tx(core_tx),
    .core_suspend(core_suspend), .core_resume_req(core_resume_req),
    .core_resume(core_resume), .core_reattach(core_reattach), .ep_set_audio(ep_set_audio),
    .max_power(max_power), .usb_pad(usb_pad), .pullup_int_en(pullup_int_en),
    .gpio_i(gpio_i), .gpio_o(gpio_o), .gpio_oe(gpio_oe), .radio_en(radio_en), .irq(irq));
  uad_host_model host_u (.hclk(hclk), .det_req(det_req), .vbus_on(vbus_on),
    .bus_idle(bus_idle), .pullup_int_en(pullup_int_en), .gpio_o(gpio_o),
    .gpio_oe(gpio_oe), .gpio_i(gpio_i), .core_suspend(core_suspend),
    .host_att(host_att), .wake_seen(wake_seen));

  // ****************************************
  // Clock, random core traffic, read monitor
  // ****************************************
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs
  always @(posedge hclk) begin
    rng     <= xs(rng);
    core_tx <= uad_usb_tx_t'(rng[2:0]);
  end
  // Oldest note pairs with the read data phase now ending
  always @(posedge hclk) begin
    if (rd_ph) begin
      e = expq.pop_front();
      samples_checked++;
      if (hrdata !== e) begin
        n_mismatch++;
        $display("MISMATCH %0t read %h want %h", $time, hrdata, e);
      end
    end
    rd_ph <= hresetn && hsel && htrans[1] && !hwrite && hreadyout;
  end

  // ****************************************
  // Tasks
  // ****************************************
  task complete_run;
    if (n_mismatch == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : complete_run
  task automatic chk(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %0t pin %b want %b", $time, got, exp);
    end
  endtask : chk
  // Bounded wait for hready, sampled at the edge
  task automatic wait_rdy;
    int k;
    k = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1) begin
      if (++k > 50) begin n_mismatch++; complete_run; end
      @(posedge hclk);
    end
  endtask : wait_rdy
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1; haddr <= {24'h0000_00, a}; htrans <= 2'b10; hwrite <= wr;
    wait_rdy;
    hsel <= 1'b0; htrans <= 2'b00; hwdata <= d;
    wait_rdy;
  endtask : xfer
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    expq.push_back(x);
    xfer(1'b0, a, 32'h0000_0000);
  endtask : rd
  task automatic settle(input int n);
    repeat (n) @(posedge hclk);
    #1;
  endtask : settle

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    hresetn = 1'b0; hsel = 1'b0; haddr = '0; htrans = '0; hwrite = 1'b0;
    hsize = 3'b010; hwdata = '0; core_resume_req = 1'b0; det_req = 1'b0;
    vbus_on = 1'b0; bus_idle = 1'b0; rng = 32'h5497_1fee; core_tx = '0; rd_ph = 1'b0;
    n_mismatch = 0; samples_checked = 0;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    // Reset values, unmapped hole, random mask round trip
    rd(OFS_PULLUP, 32'h0000_0010);
    rd(OFS_POWER, {24'h0000_00, MAX_POWER_CODE});
    rd(8'h40, 32'h0000_0000);
    chk(pullup_int_en, 1'b0);
    m = rng;
    xfer(1'b1, OFS_IRQ_MASK, m);
    rd(OFS_IRQ_MASK, m & 32'h0000_003F);
    // Ready, audio set, wake request armed
    xfer(1'b1, OFS_CTRL, 32'h0000_000D);
    settle(6);
    chk(pullup_int_en, 1'b1);
    chk(ep_set_audio, 1'b1);
    xfer(1'b1, OFS_DETACH, 32'h0000_0003);
    xfer(1'b1, OFS_WAKE, 32'h0000_0005);
    xfer(1'b1, OFS_IRQ_STAT, 32'h0000_003F);
    xfer(1'b1, OFS_IRQ_MASK, 32'h0000_0004);
    settle(1);
    chk(irq, 1'b0);
    // Detach: pads float, pull-up off, wake line up, no in-band resume
    @(posedge hclk) det_req <= 1'b1;
    settle(8);
    chk(usb_pad.dp_oe | usb_pad.dm_oe, 1'b0);
    chk(host_att, 1'b0);
    chk(wake_seen, 1'b1);
    chk(irq, 1'b1);
    @(posedge hclk) core_resume_req <= 1'b1;
    settle(2);
    chk(core_resume, 1'b0);
    @(posedge hclk) core_resume_req <= 1'b0;
    xfer(1'b1, OFS_IRQ_STAT, 32'h0000_0004);
    settle(1);
    chk(irq, 1'b0);
    @(posedge hclk) det_req <= 1'b0;
    i = 0;
    while (core_reattach !== 1'b1) begin
      if (++i > 40) begin n_mismatch++; complete_run; end
      @(negedge hclk);
    end
    @(negedge hclk);
    chk(core_reattach, 1'b0);
    settle(4);
    chk(wake_seen, 1'b0);
    chk(host_att, 1'b1);
    // Bus-powered suspend stops the radio
    @(posedge hclk) bus_idle <= 1'b1;
    settle(6);
    chk(radio_en, 1'b0);
    @(posedge hclk) core_resume_req <= 1'b1;
    settle(1);
    chk(core_resume, 1'b1);
    @(posedge hclk) core_resume_req <= 1'b0;
    bus_idle <= 1'b0;
    settle(6);
    chk(radio_en, 1'b1);
    // Self powered with external pull-up, bus power sensed on a line
    xfer(1'b1, OFS_BUS_PWR, 32'h0000_0007);
    xfer(1'b1, OFS_PULLUP, 32'h0000_0009);
    xfer(1'b1, OFS_CTRL, 32'h0000_0003);
    settle(8);
    chk(gpio_oe[9], 1'b0);
    chk(pullup_int_en, 1'b0);
    rd(OFS_POWER, 32'h0000_0000);
    @(posedge hclk) vbus_on <= 1'b1;
    settle(8);
    chk(gpio_oe[9] & gpio_o[9], 1'b1);
    chk(pullup_int_en, 1'b0);
    complete_run;
  end
endmodule : tb_top
